// ---- verilog/eecpc_ctrl.sv ----
/*
 * Nonvolatile memory commit and program control: loads the eeprom image
 * into live registers, saves live registers to the sram image, runs the
 * unlock-gated erase/program cycles and keeps count, stored crc and error.
 * Assumes a byte register port from the serial interface, a txn_end pulse
 * at each serial transaction end, and a memory macro with one-cycle reads.
 */
`timescale 1ns/100ps
`default_nettype none

module eecpc_ctrl #(
    parameter int IMG_BYTES = `EECPC_IMG_BYTES,
    parameter int ERASE_CYCLES = `EECPC_ERASE_MS * `EECPC_CLK_KHZ,
    parameter int PROG_CYCLES = `EECPC_PROG_MS * `EECPC_CLK_KHZ,
    parameter logic [7:0] UNLOCK_CODE = `EECPC_UNLOCK_DEF
) (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire eecpc_pkg::eecpc_reg_req_t reg_req_in,
    input wire logic txn_end_in,
    output logic reg_rd_ready_out,
    output logic reg_rd_valid_out,
    output logic [7:0] reg_rdata_out,
    output eecpc_pkg::eecpc_mem_req_t mem_req_out,
    input wire logic [7:0] mem_rdata_in,
    output eecpc_pkg::eecpc_live_req_t live_req_out,
    output logic [`EECPC_IMG_AW-1:0] live_raddr_out,
    input wire logic [7:0] live_rdata_in,
    output logic nvm_erase_out,
    output logic nvm_prog_out,
    output logic mem_blocked_out
);
    import eecpc_pkg::*;

    localparam int AW = `EECPC_IMG_AW;
    localparam logic [AW-1:0] IDX_LAST = AW'(IMG_BYTES - 1);
    localparam logic [AW-1:0] IDX_CNT = AW'(IMG_BYTES - 2);
    localparam logic [AW-1:0] IDX_CFG_LAST = AW'(IMG_BYTES - 3);
    localparam logic [`EECPC_TMR_W-1:0] ERASE_LOAD = `EECPC_TMR_W'(ERASE_CYCLES);
    localparam logic [`EECPC_TMR_W-1:0] PROG_LOAD = `EECPC_TMR_W'(PROG_CYCLES);

    // ------------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------------
    initial begin
        if (IMG_BYTES < 4 || IMG_BYTES > (1 << AW)) begin
            $error("eecpc_ctrl: IMG_BYTES out of range");
        end
        if (ERASE_CYCLES < 1 || ERASE_CYCLES >= (1 << `EECPC_TMR_W)) begin
            $error("eecpc_ctrl: ERASE_CYCLES out of range");
        end
        if (PROG_CYCLES < 1 || PROG_CYCLES >= (1 << `EECPC_TMR_W)) begin
            $error("eecpc_ctrl: PROG_CYCLES out of range");
        end
    end

    eecpc_state_t state;
    logic [AW-1:0] idx;
    logic [7:0] crc_acc;
    logic [7:0] stored_crc;
    logic [7:0] cycle_count;
    logic crc_error;
    logic auto_crc;
    logic want_load;
    logic want_save;
    logic want_erase;
    logic want_prog;
    logic run_prog;
    logic unlock_cur;
    logic unlock_prev;
    logic busy;
    logic loading;
    logic idle;
    logic ctl_wr;
    logic tmr_start;
    logic [`EECPC_TMR_W-1:0] tmr_load;
    logic tmr_done;
    logic [7:0] next_count;

    // ------------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------------
    assign idle = (state == ST_IDLE);
    assign loading = (state == ST_LD_RD) || (state == ST_LD_WR);
    assign ctl_wr = reg_req_in.wr && (reg_req_in.addr == `EECPC_OFS_CTL);

    assign busy = (state == ST_CNT_WR) || (state == ST_CRC_RD) || (state == ST_CRC_ACC) ||
                  (state == ST_CRC_WR) || (state == ST_ERASE) || (state == ST_PROG) ||
                  (state == ST_RLD_RD) || (state == ST_RLD_WR);
    assign mem_blocked_out = busy;

    assign next_count = (cycle_count == `EECPC_CNT_MAX) ? cycle_count : cycle_count + 8'h01;

    // ------------------------------------------------------------------
    // unlock tracking: only the transaction right before may unlock
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            unlock_cur <= 1'b0;
            unlock_prev <= 1'b0;
        end else if (txn_end_in) begin
            // the closing write alone decides, so a later write spoils it
            unlock_prev <= reg_req_in.wr ? (reg_req_in.addr == `EECPC_OFS_UNLK &&
                           reg_req_in.wdata == UNLOCK_CODE) : unlock_cur;
            unlock_cur <= 1'b0;
        end else if (reg_req_in.wr) begin
            // any other write in the transaction spoils the unlock
            unlock_cur <= (reg_req_in.addr == `EECPC_OFS_UNLK) &&
                          (reg_req_in.wdata == UNLOCK_CODE);
        end
    end

    // ------------------------------------------------------------------
    // software settings
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            auto_crc <= `EECPC_RST_AUTOCRC;
        end else if (ctl_wr) begin
            auto_crc <= reg_req_in.wdata[`EECPC_BIT_AUTOCRC];
        end
    end

    // ------------------------------------------------------------------
    // pending operation requests; a write in the taking cycle wins
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            want_load <= 1'b1;
            want_save <= 1'b0;
            want_erase <= 1'b0;
            want_prog <= 1'b0;
        end else begin
            if (idle) begin
                if (want_load) begin
                    want_load <= 1'b0;
                end else if (want_save) begin
                    want_save <= 1'b0;
                end else begin
                    want_erase <= 1'b0;
                    want_prog <= 1'b0;
                end
            end
            if (ctl_wr && !busy) begin
                if (reg_req_in.wdata[`EECPC_BIT_MEMCMT]) begin
                    want_load <= 1'b1;
                end
                if (reg_req_in.wdata[`EECPC_BIT_REGCMT]) begin
                    want_save <= 1'b1;
                end
                if (reg_req_in.wdata[`EECPC_BIT_ERASE] && unlock_prev) begin
                    want_erase <= 1'b1;
                end
                if (reg_req_in.wdata[`EECPC_BIT_PROG] && unlock_prev) begin
                    want_prog <= 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state <= ST_IDLE;
            idx <= '0;
            crc_acc <= `EECPC_CRC_INIT;
            run_prog <= 1'b0;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    idx <= '0;
                    crc_acc <= `EECPC_CRC_INIT;
                    if (want_load) begin
                        state <= ST_LD_RD;
                    end else if (want_save) begin
                        state <= ST_SAVE;
                    end else if (want_erase) begin
                        // combined cycle remembers the program half
                        run_prog <= want_prog;
                        state <= ST_ERASE;
                    end else if (want_prog) begin
                        run_prog <= 1'b1;
                        state <= ST_CNT_WR;
                    end
                end
                ST_LD_RD: begin
                    state <= ST_LD_WR;
                end
                ST_LD_WR: begin
                    if (idx != IDX_LAST) begin
                        crc_acc <= eecpc_crc8(crc_acc, mem_rdata_in);
                    end
                    idx <= idx + 1'b1;
                    state <= (idx == IDX_LAST) ? ST_IDLE : ST_LD_RD;
                end
                ST_SAVE: begin
                    idx <= idx + 1'b1;
                    if (idx == IDX_CFG_LAST) begin
                        state <= ST_IDLE;
                    end
                end
                ST_ERASE: begin
                    if (tmr_done) begin
                        // straight into the program half if combined, else reload; no idle gap
                        state <= run_prog ? ST_CNT_WR : ST_RLD_RD;
                    end
                end
                ST_CNT_WR: begin
                    idx <= '0;
                    state <= ST_CRC_RD;
                end
                ST_CRC_RD: begin
                    state <= ST_CRC_ACC;
                end
                ST_CRC_ACC: begin
                    crc_acc <= eecpc_crc8(crc_acc, mem_rdata_in);
                    idx <= idx + 1'b1;
                    state <= (idx == IDX_CNT) ? ST_CRC_WR : ST_CRC_RD;
                end
                ST_CRC_WR: begin
                    state <= ST_PROG;
                end
                ST_PROG: begin
                    if (tmr_done) begin
                        run_prog <= 1'b0;
                        state <= ST_RLD_RD;
                    end
                end
                ST_RLD_RD: begin
                    state <= ST_RLD_WR;
                end
                ST_RLD_WR: begin
                    state <= ST_IDLE;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // phase timer, started on entry to erase or program
    // ------------------------------------------------------------------
    always_comb begin
        tmr_start = 1'b0;
        tmr_load = ERASE_LOAD;
        if (idle && !want_load && !want_save && want_erase) begin
            tmr_start = 1'b1;
        end
        if (state == ST_CRC_WR) begin
            tmr_start = 1'b1;
            tmr_load = PROG_LOAD;
        end
    end

    eecpc_timer #(
        .CNT_W(`EECPC_TMR_W)
    ) u_timer (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .start_in(tmr_start),
        .load_in(tmr_load),
        .done_out(tmr_done)
    );

    assign nvm_erase_out = (state == ST_ERASE);
    assign nvm_prog_out = (state == ST_PROG);

    // ------------------------------------------------------------------
    // captured image values and crc check
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            stored_crc <= `EECPC_RST_CRC;
            cycle_count <= `EECPC_RST_CNT;
            crc_error <= 1'b0;
        end else if (state == ST_LD_WR) begin
            if (idx == IDX_CNT) begin
                cycle_count <= mem_rdata_in;
            end
            if (idx == IDX_LAST) begin
                stored_crc <= mem_rdata_in;
                crc_error <= (mem_rdata_in != crc_acc);
            end
        end else if (state == ST_RLD_WR) begin
            cycle_count <= mem_rdata_in;
        end
    end

    // ------------------------------------------------------------------
    // memory and live register requests, decoded from sequencer flops
    // ------------------------------------------------------------------
    always_comb begin
        mem_req_out = '0;
        live_req_out = '0;
        live_raddr_out = idx;
        unique case (state)
            ST_LD_RD: begin
                mem_req_out.eeprom = 1'b1;
                mem_req_out.addr = idx;
            end
            ST_LD_WR: begin
                live_req_out.we = (idx < IDX_CNT);
                live_req_out.addr = idx;
                live_req_out.wdata = mem_rdata_in;
            end
            ST_SAVE: begin
                mem_req_out.we = 1'b1;
                mem_req_out.addr = idx;
                mem_req_out.wdata = live_rdata_in;
            end
            ST_CNT_WR: begin
                // incremented count goes into the image
                mem_req_out.we = 1'b1;
                mem_req_out.addr = IDX_CNT;
                mem_req_out.wdata = next_count;
            end
            ST_CRC_RD: begin
                mem_req_out.addr = idx;
            end
            ST_CRC_WR: begin
                // stored crc written only when automatic
                mem_req_out.we = auto_crc;
                mem_req_out.addr = IDX_LAST;
                mem_req_out.wdata = crc_acc;
            end
            ST_RLD_RD: begin
                mem_req_out.eeprom = 1'b1;
                mem_req_out.addr = IDX_CNT;
            end
            default: begin
                mem_req_out = '0;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // register reads; refused while the memory image is loading
    // ------------------------------------------------------------------
    // no reads during load
    assign reg_rd_ready_out = !loading && !want_load;

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            reg_rd_valid_out <= 1'b0;
            reg_rdata_out <= 8'h00;
        end else begin
            reg_rd_valid_out <= reg_req_in.rd && reg_rd_ready_out;
            if (reg_req_in.rd && reg_rd_ready_out) begin
                unique case (reg_req_in.addr)
                    `EECPC_OFS_CRC: reg_rdata_out <= stored_crc;
                    `EECPC_OFS_CNT: reg_rdata_out <= cycle_count;
                    `EECPC_OFS_CTL: begin
                        reg_rdata_out <= {1'b0, want_save || (state == ST_SAVE), crc_error,
                                          auto_crc, want_load || loading, busy,
                                          want_erase || (state == ST_ERASE),
                                          want_prog || run_prog};
                    end
                    default: reg_rdata_out <= 8'h00;
                endcase
            end
        end
    end

endmodule : eecpc_ctrl

`default_nettype wire

// ---- verilog/eecpc_map.svh ----
/*
 * Register offsets, field positions, reset values and timing figures of the
 * nonvolatile memory commit and program control block.
 * Assumes a 100 MHz device clock and an image of at most 32 bytes.
 */
//
// Behaviour
// - stored crc byte readable, read-only
// - count increments after each program or erase+program cycle, erase alone reloads it
// - count reloads after reset, commit, cycle
// - count saturates at 255, never wraps
// - register commit copies live into sram
// - crc mismatch on load sets error flag
// - auto crc computes stored crc on program
// - memory loads into registers after reset/commit
// - register reads refused during memory commit
// - busy high during erase/program, memory blocked
// - erase starts only after unlock transaction
// - program starts only after unlock transaction
// - erase and program together run combined
// - erase lasts about 115 ms
// - program lasts about 115 ms
`ifndef EECPC_MAP_SVH
`define EECPC_MAP_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define EECPC_OFS_CRC 8'h2F
`define EECPC_OFS_CNT 8'h30
`define EECPC_OFS_CTL 8'h31
`define EECPC_OFS_UNLK 8'h38

// ----------------------------------------------------------------------
// control and status field positions
// ----------------------------------------------------------------------
`define EECPC_BIT_REGCMT 6
`define EECPC_BIT_CRCERR 5
`define EECPC_BIT_AUTOCRC 4
`define EECPC_BIT_MEMCMT 3
`define EECPC_BIT_BUSY 2
`define EECPC_BIT_ERASE 1
`define EECPC_BIT_PROG 0

// ----------------------------------------------------------------------
// reset values and codes
// ----------------------------------------------------------------------
`define EECPC_RST_CRC 8'h00
`define EECPC_RST_CNT 8'h00
`define EECPC_RST_AUTOCRC 1'b1
`define EECPC_CNT_MAX 8'hFF
`define EECPC_UNLOCK_DEF 8'h5A
`define EECPC_CRC_POLY 8'h07
`define EECPC_CRC_INIT 8'h00

// ----------------------------------------------------------------------
// image geometry and timing
// ----------------------------------------------------------------------
`define EECPC_IMG_BYTES 32
`define EECPC_IMG_AW 5
`define EECPC_CLK_KHZ 100000
`define EECPC_ERASE_MS 115
`define EECPC_PROG_MS 115
`define EECPC_TMR_W 24

`endif

// ---- verilog/eecpc_pkg.sv ----
/*
 * Types shared by the commit and program control block and its timer.
 * Assumes eecpc_map.svh is on the include path.
 */
`include "eecpc_map.svh"

package eecpc_pkg;

    // ------------------------------------------------------------------
    // controller states, gray coded in listed order, not along every path
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_LD_RD = 4'h1,
        ST_LD_WR = 4'h3,
        ST_SAVE = 4'h2,
        ST_CNT_WR = 4'h6,
        ST_CRC_RD = 4'h7,
        ST_CRC_ACC = 4'h5,
        ST_CRC_WR = 4'h4,
        ST_ERASE = 4'hC,
        ST_PROG = 4'hD,
        ST_RLD_RD = 4'hF,
        ST_RLD_WR = 4'hE
    } eecpc_state_t;

    // register access from the serial interface
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } eecpc_reg_req_t;

    // request to the eeprom/sram macro, read data one cycle later
    typedef struct packed {
        logic eeprom;
        logic we;
        logic [`EECPC_IMG_AW-1:0] addr;
        logic [7:0] wdata;
    } eecpc_mem_req_t;

    // write into the live configuration registers
    typedef struct packed {
        logic we;
        logic [`EECPC_IMG_AW-1:0] addr;
        logic [7:0] wdata;
    } eecpc_live_req_t;

    // one step of crc-8, msb first
    function automatic logic [7:0] eecpc_crc8(input logic [7:0] crc, input logic [7:0] data);
        logic [7:0] c;
        c = crc ^ data;
        for (int i = 0; i < 8; i++) begin
            c = c[7] ? ((c << 1) ^ `EECPC_CRC_POLY) : (c << 1);
        end
        return c;
    endfunction : eecpc_crc8

endpackage : eecpc_pkg

// ---- verilog/eecpc_timer.sv ----
/*
 * Down-counting interval timer for the erase and program phases.
 * Assumes start_in is a one-cycle pulse and load_in is at least one.
 */
`timescale 1ns/100ps
`default_nettype none

module eecpc_timer #(
    parameter int CNT_W = `EECPC_TMR_W
) (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic start_in,
    input wire logic [CNT_W-1:0] load_in,
    output logic done_out
);
    import eecpc_pkg::*;

    logic [CNT_W-1:0] remain;
    logic running;

    initial begin
        if (CNT_W < 2 || CNT_W > 31) begin
            $error("eecpc_timer: CNT_W out of range");
        end
    end

    // ------------------------------------------------------------------
    // count down; done pulses on the last cycle of the interval
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            remain <= '0;
            running <= 1'b0;
        end else if (start_in) begin
            remain <= load_in;
            running <= 1'b1;
        end else if (running) begin
            remain <= remain - 1'b1;
            running <= (remain != {{(CNT_W-1){1'b0}}, 1'b1});
        end
    end

    assign done_out = running && (remain == {{(CNT_W-1){1'b0}}, 1'b1});

endmodule : eecpc_timer

`default_nettype wire

// ---- testbench/eecpc_ctrl_assertions.sv ----
/* port checker of the commit and program control block.
   assumes eecpc_pkg is compiled first; bound to every eecpc_ctrl. */
`timescale 1ns/100ps
`default_nettype none

module eecpc_ctrl_chk #(
    parameter int ERASE_CYCLES = 20,
    parameter int PROG_CYCLES = 20
) (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire eecpc_pkg::eecpc_reg_req_t reg_req_in,
    input wire logic reg_rd_ready_out,
    input wire logic reg_rd_valid_out,
    input wire eecpc_pkg::eecpc_live_req_t live_req_out,
    input wire logic nvm_erase_out,
    input wire logic nvm_prog_out,
    input wire logic mem_blocked_out
);
    import eecpc_pkg::*;
    int ecnt;
    int pcnt;
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);

    // ----
    // phase length counters, cleared whenever the phase is off
    // ----
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            ecnt <= 0;
            pcnt <= 0;
        end else begin
            ecnt <= nvm_erase_out ? ecnt + 1 : 0;
            pcnt <= nvm_prog_out ? pcnt + 1 : 0;
        end
    end

    a_prog_busy: assert property (nvm_prog_out |-> mem_blocked_out)
        else $error("program phase without busy");
    a_erase_busy: assert property (nvm_erase_out |-> mem_blocked_out)
        else $error("erase phase without busy");
    a_live_blocked: assert property (mem_blocked_out |-> !live_req_out.we)
        else $error("live write while busy");
    a_phase_apart: assert property (!(nvm_erase_out && nvm_prog_out))
        else $error("erase and program overlap");
    a_erase_gapless: assert property ($fell(nvm_erase_out) |-> mem_blocked_out)
        else $error("busy gap after erase");
    a_read_answer: assert property (reg_req_in.rd && reg_rd_ready_out |=> reg_rd_valid_out)
        else $error("accepted read not answered");
    a_read_refused: assert property (reg_req_in.rd && !reg_rd_ready_out |=> !reg_rd_valid_out)
        else $error("read answered during load");
    a_load_first: assert property ($past(rst_in) |-> !reg_rd_ready_out)
        else $error("reads open before load");
    // roughly the set count, one cycle either way
    a_erase_len: assert property ($fell(nvm_erase_out) |->
        ecnt >= ERASE_CYCLES - 1 && ecnt <= ERASE_CYCLES + 1) else $error("erase length off");
    a_prog_len: assert property ($fell(nvm_prog_out) |->
        pcnt >= PROG_CYCLES - 1 && pcnt <= PROG_CYCLES + 1) else $error("program length off");

    c_prog: cover property ($rose(nvm_prog_out));
    c_erase: cover property ($rose(nvm_erase_out));
    c_refused: cover property (reg_req_in.rd && !reg_rd_ready_out);
endmodule : eecpc_ctrl_chk

bind eecpc_ctrl eecpc_ctrl_chk #(.ERASE_CYCLES(ERASE_CYCLES), .PROG_CYCLES(PROG_CYCLES)) u_chk (
    .ref_clk_in, .rst_in, .reg_req_in, .reg_rd_ready_out, .reg_rd_valid_out,
    .live_req_out, .nvm_erase_out, .nvm_prog_out, .mem_blocked_out);

`default_nettype wire

// ---- testbench/eecpc_mem_model.sv ----
/* eeprom, sram image and live register model behind the control block.
   assumes one-cycle reads and eecpc_pkg compiled first. */
`timescale 1ns/100ps
`default_nettype none

module eecpc_mem_model (
    input wire logic ref_clk_in,
    input wire eecpc_pkg::eecpc_mem_req_t mem_req_in,
    output logic [7:0] mem_rdata_out,
    input wire eecpc_pkg::eecpc_live_req_t live_req_in,
    input wire logic [4:0] live_raddr_in,
    output logic [7:0] live_rdata_out,
    input wire logic erase_in,
    input wire logic prog_in
);
    import eecpc_pkg::*;
    logic [7:0] ee [32];
    logic [7:0] sr [32];
    logic [7:0] live [32];

    // ----
    // contents: zero config so the stored crc A5 is known to be wrong
    // ----
    initial begin
        mem_rdata_out = 8'h00;
        for (int i = 0; i < 32; i++) begin
            ee[i] = 8'h00;
            sr[i] = 8'hC3;
            live[i] = 8'h5C;
        end
        ee[30] = 8'hFE;
        ee[31] = 8'hA5;
    end

    // one-cycle read; erase floods ones, program copies the sram image
    always @(posedge ref_clk_in) begin
        mem_rdata_out <= mem_req_in.eeprom ? ee[mem_req_in.addr] : sr[mem_req_in.addr];
        if (mem_req_in.we && !mem_req_in.eeprom) begin
            sr[mem_req_in.addr] <= mem_req_in.wdata;
        end
        if (live_req_in.we) begin
            live[live_req_in.addr] <= live_req_in.wdata;
        end
        for (int i = 0; i < 32; i++) begin
            if (erase_in) begin
                ee[i] <= 8'hFF;
            end else if (prog_in) begin
                ee[i] <= sr[i];
            end
        end
    end

    assign live_rdata_out = live[live_raddr_in];
endmodule : eecpc_mem_model

`default_nettype wire

// ---- testbench/tb_top.sv ----
/* self-checking bench of the commit and program control block.
   assumes the design, package, model and checker are compiled first. */
`timescale 1ns/100ps
`default_nettype none

module tb_top;
    import eecpc_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    eecpc_reg_req_t req = '0;
    logic tend = 1'b0;
    logic rdy;
    logic vld;
    logic [7:0] rdat;
    logic [7:0] mrd;
    logic [7:0] lrd;
    logic [4:0] lra;
    eecpc_mem_req_t mreq;
    eecpc_live_req_t lreq;
    logic ers;
    logic prg;
    logic blk;
    logic [7:0] v;
    int fail_count = 0;
    int tests_run = 0;

    always #5 clk = ~clk;

    eecpc_ctrl #(.ERASE_CYCLES(20), .PROG_CYCLES(20)) u_dut (.ref_clk_in(clk), .rst_in(rst),
        .reg_req_in(req), .txn_end_in(tend), .reg_rd_ready_out(rdy), .reg_rd_valid_out(vld),
        .reg_rdata_out(rdat), .mem_req_out(mreq), .mem_rdata_in(mrd), .live_req_out(lreq),
        .live_raddr_out(lra), .live_rdata_in(lrd), .nvm_erase_out(ers), .nvm_prog_out(prg),
        .mem_blocked_out(blk));
    eecpc_mem_model u_mem (.ref_clk_in(clk), .mem_req_in(mreq), .mem_rdata_out(mrd),
        .live_req_in(lreq), .live_raddr_in(lra), .live_rdata_out(lrd), .erase_in(ers),
        .prog_in(prg));

    task automatic test_done;
        if (fail_count == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : test_done

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // one write, txn_end marks the end of its serial transaction
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic e);
        @(posedge clk);
        #1 req = '{1'b1, 1'b0, a, d};
        tend = e;
        @(posedge clk);
        #1 req = '0;
        tend = 1'b0;
    endtask : wr

    // reads stay off the port while a load runs; bounded wait
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        #1;
        while (rdy !== 1'b1) begin
            n++;
            if (n > 400) begin
                fail_count++;
                test_done;
            end
            @(posedge clk);
            #1;
        end
        req = '{1'b0, 1'b1, a, 8'h00};
        @(posedge clk);
        #1 req = '0;
        d = (vld === 1'b1) ? rdat : 8'hXX;
    endtask : rd

    // poll control until no start bit pends and busy is low
    task automatic wait_idle;
        int n;
        n = 0;
        v = 8'hFF;
        while ((v & 8'h4F) !== 8'h00) begin
            n++;
            if (n > 300) begin
                fail_count++;
                test_done;
            end
            rd(8'h31, v);
        end
    endtask : wait_idle

    initial begin
        repeat (5) @(posedge clk);
        #1 rst = 1'b0;
        // ----
        // load after reset, then locked starts and a save
        // ----
        rd(8'h2F, v);
        chk(v, 8'hA5);
        rd(8'h30, v);
        chk(v, 8'hFE);
        rd(8'h31, v);
        chk(v, 8'h30);
        chk(u_mem.live[7], 8'h00);
        rd(8'h32, v);
        chk(v, 8'h00);
        wr(8'h31, 8'h13, 1'b1);
        rd(8'h31, v);
        chk(v, 8'h30);
        wr(8'h31, 8'h50, 1'b1);
        wait_idle;
        chk(u_mem.sr[7], 8'h00);
        // ----
        // unlocked erase plus program, then reload and saturation
        // ----
        wr(8'h38, 8'h5A, 1'b1);
        wr(8'h31, 8'h13, 1'b1);
        rd(8'h31, v);
        chk(v, 8'h37);
        wait_idle;
        rd(8'h30, v);
        chk(v, 8'hFF);
        chk(u_mem.sr[31], 8'hF3);
        wr(8'h31, 8'h18, 1'b1);
        @(posedge clk);
        #1 req = '{1'b0, 1'b1, 8'h30, 8'h00};
        @(posedge clk);
        #1 req = '0;
        chk({7'h00, vld}, 8'h00);
        wait_idle;
        rd(8'h31, v);
        chk(v, 8'h10);
        wr(8'h38, 8'h5A, 1'b1);
        wr(8'h31, 8'h11, 1'b1);
        wait_idle;
        rd(8'h30, v);
        chk(v, 8'hFF);
        // a second write after the unlock spoils it
        wr(8'h38, 8'h5A, 1'b0);
        wr(8'h2F, 8'h00, 1'b1);
        wr(8'h31, 8'h11, 1'b1);
        rd(8'h31, v);
        chk(v, 8'h10);
        test_done;
    end
endmodule : tb_top

`default_nettype wire
